// file: mies_pkg.sv
// package: opcodes, flag layout, reset values and carriers for the exec subset
package mies_pkg;

    localparam int DATA_W  = 8;
    localparam int ADDR_W  = 8;
    localparam int PROG_W  = 16;
    localparam int PAGE_W  = 8;
    localparam int PADDR_W = 12;

    // flag positions inside the status vector
    localparam int FLAG_CARRY  = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO   = 2;
    localparam int FLAG_WRAP   = 3;

    localparam logic [7:0] WORK_RST    = 8'h00;
    localparam logic [3:0] FLAGS_RST   = 4'h0;
    localparam logic [7:0] TBL_HI_RST  = 8'h00;
    localparam logic [3:0] LAST_PAGE   = 4'hF;
    localparam logic [1:0] SKIP_CYCLES = 2'h2;

    typedef enum logic [3:0] {
        MIES_OP_INC_WORK_SKIP = 4'h0,
        MIES_OP_SKIP_BIT_SET  = 4'h1,
        MIES_OP_SUB_WORK      = 4'h2,
        MIES_OP_SUB_MEM       = 4'h3,
        MIES_OP_SUB_IMM       = 4'h4,
        MIES_OP_SWAP_MEM      = 4'h5,
        MIES_OP_SWAP_WORK     = 4'h6,
        MIES_OP_SKIP_ZERO     = 4'h7,
        MIES_OP_MOVE_SKIP     = 4'h8,
        MIES_OP_SKIP_BIT_CLR  = 4'h9,
        MIES_OP_TBL_CUR       = 4'hA,
        MIES_OP_TBL_LAST      = 4'hB,
        MIES_OP_XOR_WORK      = 4'hC,
        MIES_OP_XOR_MEM       = 4'hD,
        MIES_OP_XOR_IMM       = 4'hE
    } mies_op_t;

    typedef enum logic [1:0] {
        MIES_ST_IDLE  = 2'b00,
        MIES_ST_TABLE = 2'b01,
        MIES_ST_DUMMY = 2'b10
    } mies_state_t;

    typedef struct packed {
        mies_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] imm;
        logic [2:0]        bit_sel;
    } mies_instr_t;

    typedef struct packed {
        logic [DATA_W-1:0] result;
        logic [3:0]        flags;
    } mies_alu_t;

endpackage : mies_pkg

// file: mies_sub.sv
// subtractor with flags for work register minus operand
`timescale 1ns/1ps
`default_nettype none
module mies_sub
    import mies_pkg::*;
(
    input  wire logic [DATA_W-1:0] minuend,
    input  wire logic [DATA_W-1:0] subtrahend,
    output var  mies_alu_t         out
);
    logic [DATA_W:0] diff;
    logic [4:0]      low;

    always_comb begin
        diff = {1'b0, minuend} - {1'b0, subtrahend};
        low  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
        out.result               = diff[DATA_W-1:0];
        // carry clear means a borrow happened, i.e. negative result
        out.flags[FLAG_CARRY]    = ~diff[DATA_W];
        out.flags[FLAG_NIBBLE]   = ~low[4];
        out.flags[FLAG_ZERO]     = (diff[DATA_W-1:0] == 8'h00);
        out.flags[FLAG_WRAP]     = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff[7]);
    end
endmodule : mies_sub
`default_nettype wire

// file: mies_exec.sv
// instruction execution subset: skips, subtract, swap, table read, xor
//
// Function
// - increment-to-work: work gets memory plus one, memory kept, skip on zero
// - every taken skip lasts two cycles via an inserted dummy cycle
// - bit-set test skips next instruction when selected bit is one
// - subtract memory from work into work, update wrap, zero, nibble, carry
// - subtraction carry clears on negative result, sets on positive or zero
// - subtract with difference written back to memory, all four flags updated
// - subtract immediate from work into work, all four flags updated
// - nibble exchange in place writes swapped byte to memory, flags untouched
// - nibble exchange to work: swapped byte into work, memory unchanged
// - byte-zero test skips next instruction when memory byte is zero
// - move-and-test copies memory to work, skips when the value is zero
// - bit-clear test skips next instruction when selected bit is zero
// - current-page table read: low byte to memory, high byte to table-high
// - last-page table read: same, from the final program page
// - xor memory into work, update only zero flag
// - xor written back to memory, update only zero flag
// - xor immediate into work, update only zero flag
//
`timescale 1ns/1ps
`default_nettype none
module mies_exec
    import mies_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                instr_valid,
    input  wire mies_instr_t         instr,
    input  wire logic [PAGE_W-1:0]   table_pointer,
    input  wire logic [3:0]          cur_page,
    input  wire logic [DATA_W-1:0]   mem_rdata,
    input  wire logic [PROG_W-1:0]   prog_rdata,
    output logic                     busy,
    output logic                     mem_we,
    output logic [ADDR_W-1:0]        mem_addr,
    output logic [DATA_W-1:0]        mem_wdata,
    output logic                     prog_re,
    output logic [PADDR_W-1:0]       prog_addr,
    output logic                     skip_next,
    output logic                     done,
    output logic [DATA_W-1:0]        work_register,
    output logic [DATA_W-1:0]        table_high_byte,
    output logic [3:0]               status_flags
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mies_state_t        st;
        logic [ADDR_W-1:0]  tbl_addr;
        logic               busy;
        logic               mem_we;
        logic [ADDR_W-1:0]  mem_addr;
        logic [DATA_W-1:0]  mem_wdata;
        logic               prog_re;
        logic [PADDR_W-1:0] prog_addr;
        logic               skip_next;
        logic               done;
        logic [DATA_W-1:0]  work;
        logic [DATA_W-1:0]  tbl_hi;
        logic [3:0]         flags;
    } mies_regs_t;

    mies_regs_t s_q;
    mies_regs_t s_d;
    mies_alu_t  sub_out;
    logic [DATA_W-1:0] sub_rhs;

    function automatic logic [DATA_W-1:0] swap_nib(input logic [DATA_W-1:0] v);
        swap_nib = {v[3:0], v[7:4]};
    endfunction : swap_nib

    function automatic logic [3:0] with_zero(input logic [3:0] f,
                                             input logic [DATA_W-1:0] r);
        logic [3:0] t;
        t = f;
        t[FLAG_ZERO] = (r == 8'h00);
        with_zero = t;
    endfunction : with_zero

    assign sub_rhs = (instr.op == MIES_OP_SUB_IMM) ? instr.imm : mem_rdata;

    mies_sub u_sub (
        .minuend    (s_q.work),
        .subtrahend (sub_rhs),
        .out        (sub_out)
    );

    // ------------------------------------------------------------
    // execute
    // ------------------------------------------------------------
    always_comb begin
        logic [DATA_W-1:0] inc;
        logic [DATA_W-1:0] xr;
        logic              sk;
        inc = 8'(mem_rdata + 8'h01);
        xr  = s_q.work ^ ((instr.op == MIES_OP_XOR_IMM) ? instr.imm : mem_rdata);
        sk  = 1'b0;
        s_d = s_q;
        s_d.mem_we    = 1'b0;
        s_d.prog_re   = 1'b0;
        s_d.skip_next = 1'b0;
        s_d.done      = 1'b0;
        unique case (s_q.st)
            MIES_ST_IDLE: begin
                if (instr_valid) begin
                    s_d.mem_addr = instr.addr;
                    s_d.done     = 1'b1;
                    case (instr.op)
                        MIES_OP_INC_WORK_SKIP: begin
                            s_d.work = inc;
                            sk       = (inc == 8'h00);
                        end
                        MIES_OP_SKIP_BIT_SET: sk = mem_rdata[instr.bit_sel];
                        MIES_OP_SKIP_BIT_CLR: sk = ~mem_rdata[instr.bit_sel];
                        MIES_OP_SKIP_ZERO:    sk = (mem_rdata == 8'h00);
                        MIES_OP_MOVE_SKIP: begin
                            s_d.work = mem_rdata;
                            sk       = (mem_rdata == 8'h00);
                        end
                        MIES_OP_SUB_WORK, MIES_OP_SUB_IMM: begin
                            s_d.work  = sub_out.result;
                            s_d.flags = sub_out.flags;
                        end
                        MIES_OP_SUB_MEM: begin
                            s_d.mem_we    = 1'b1;
                            s_d.mem_wdata = sub_out.result;
                            s_d.flags     = sub_out.flags;
                        end
                        MIES_OP_SWAP_MEM: begin
                            s_d.mem_we    = 1'b1;
                            s_d.mem_wdata = swap_nib(mem_rdata);
                        end
                        MIES_OP_SWAP_WORK: s_d.work = swap_nib(mem_rdata);
                        MIES_OP_XOR_WORK, MIES_OP_XOR_IMM: begin
                            s_d.work  = xr;
                            s_d.flags = with_zero(s_q.flags, xr);
                        end
                        MIES_OP_XOR_MEM: begin
                            s_d.mem_we    = 1'b1;
                            s_d.mem_wdata = xr;
                            s_d.flags     = with_zero(s_q.flags, xr);
                        end
                        MIES_OP_TBL_CUR, MIES_OP_TBL_LAST: begin
                            // program memory answers one cycle later
                            s_d.done      = 1'b0;
                            s_d.busy      = 1'b1;
                            s_d.st        = MIES_ST_TABLE;
                            s_d.tbl_addr  = instr.addr;
                            s_d.prog_re   = 1'b1;
                            s_d.prog_addr = (instr.op == MIES_OP_TBL_LAST) ?
                                {LAST_PAGE, table_pointer} :
                                {cur_page, table_pointer};
                        end
                        default: s_d.done = 1'b1;
                    endcase
                    if (sk) begin
                        // dummy cycle while the next word is fetched
                        s_d.skip_next = 1'b1;
                        s_d.busy      = 1'b1;
                        s_d.done      = 1'b0;
                        s_d.st        = MIES_ST_DUMMY;
                    end
                end
            end
            MIES_ST_TABLE: begin
                s_d.mem_we    = 1'b1;
                s_d.mem_addr  = s_q.tbl_addr;
                s_d.mem_wdata = prog_rdata[7:0];
                s_d.tbl_hi    = prog_rdata[15:8];
                s_d.busy      = 1'b0;
                s_d.done      = 1'b1;
                s_d.st        = MIES_ST_IDLE;
            end
            MIES_ST_DUMMY: begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st   = MIES_ST_IDLE;
            end
            default: s_d.st = MIES_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q <= '{st: MIES_ST_IDLE, tbl_addr: '0, busy: 1'b0, mem_we: 1'b0,
                     mem_addr: '0, mem_wdata: '0, prog_re: 1'b0, prog_addr: '0,
                     skip_next: 1'b0, done: 1'b0, work: WORK_RST,
                     tbl_hi: TBL_HI_RST, flags: FLAGS_RST};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy            = s_q.busy;
    assign mem_we          = s_q.mem_we;
    assign mem_addr        = s_q.mem_addr;
    assign mem_wdata       = s_q.mem_wdata;
    assign prog_re         = s_q.prog_re;
    assign prog_addr       = s_q.prog_addr;
    assign skip_next       = s_q.skip_next;
    assign done            = s_q.done;
    assign work_register   = s_q.work;
    assign table_high_byte = s_q.tbl_hi;
    assign status_flags    = s_q.flags;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // an instruction taken at this edge
    logic issue_now;
    assign issue_now = (s_q.st == MIES_ST_IDLE) && instr_valid;

    sequence skip_start;
        s_q.skip_next && s_q.st == MIES_ST_DUMMY;
    endsequence
    sequence skip_end;
        !s_q.busy && s_q.done;
    endsequence

    a_skip_two_cycles: assert property (@(posedge clock) disable iff (!rst_n_q)
        skip_start |=> skip_end)
        else $error("skip did not end after the dummy cycle");

    a_inc_work_value: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_INC_WORK_SKIP)
        |=> s_q.work == $past(mem_rdata) + 8'h01 && !s_q.mem_we
            && s_q.skip_next == ($past(mem_rdata) == 8'hFF))
        else $error("increment to work wrong");

    a_bit_set_skip: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_SKIP_BIT_SET)
        |=> s_q.skip_next == $past(mem_rdata[instr.bit_sel]))
        else $error("bit set skip wrong");

    a_bit_clr_skip: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_SKIP_BIT_CLR)
        |=> s_q.skip_next == !$past(mem_rdata[instr.bit_sel]))
        else $error("bit clear skip wrong");

    a_sub_carry_sign: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_SUB_WORK)
        |=> s_q.flags[FLAG_CARRY] == ($past(s_q.work) >= $past(mem_rdata))
            && s_q.work == $past(s_q.work) - $past(mem_rdata))
        else $error("subtract carry wrong");

    a_swap_flags_kept: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_SWAP_MEM)
        |=> $stable(s_q.flags) && s_q.mem_we && s_q.mem_wdata == swap_nib($past(mem_rdata)))
        else $error("swap altered flags or data");

    a_xor_zero_only: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_XOR_WORK)
        |=> s_q.flags[FLAG_CARRY] == $past(s_q.flags[FLAG_CARRY])
            && s_q.flags[FLAG_ZERO] == (s_q.work == 8'h00))
        else $error("xor flags wrong");

    a_table_write: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_IDLE && instr_valid && instr.op == MIES_OP_TBL_CUR)
        |=> s_q.prog_re ##1 (s_q.mem_we && s_q.mem_wdata == $past(prog_rdata[7:0])
            && s_q.tbl_hi == $past(prog_rdata[15:8])))
        else $error("table read wrong");

    a_sub_mem_write: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_SUB_MEM)
        |=> s_q.mem_we && $stable(s_q.work)
            && s_q.mem_wdata == $past(s_q.work) - $past(mem_rdata))
        else $error("subtract to memory wrong");

    a_sub_imm_value: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_SUB_IMM)
        |=> s_q.work == $past(s_q.work) - $past(instr.imm)
            && s_q.flags[FLAG_CARRY] == ($past(s_q.work) >= $past(instr.imm)))
        else $error("subtract immediate wrong");

    a_sub_zero_flag: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op inside {MIES_OP_SUB_WORK, MIES_OP_SUB_IMM})
        |=> s_q.flags[FLAG_ZERO] == (s_q.work == 8'h00))
        else $error("subtract zero flag wrong");

    a_sub_wrap_nib: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_SUB_WORK)
        |=> s_q.flags[FLAG_NIBBLE] == ($past(s_q.work[3:0]) >= $past(mem_rdata[3:0]))
            && s_q.flags[FLAG_WRAP] == (($past(s_q.work[7]) != $past(mem_rdata[7]))
            && (s_q.work[7] != $past(s_q.work[7]))))
        else $error("subtract wrap or nibble flag wrong");

    a_swap_work_value: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_SWAP_WORK)
        |=> s_q.work == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
            && !s_q.mem_we && $stable(s_q.flags))
        else $error("swap to work wrong");

    a_skip_zero_test: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_SKIP_ZERO)
        |=> s_q.skip_next == ($past(mem_rdata) == 8'h00))
        else $error("byte zero skip wrong");

    a_move_skip_value: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_MOVE_SKIP)
        |=> s_q.work == $past(mem_rdata) && s_q.skip_next == ($past(mem_rdata) == 8'h00))
        else $error("move and skip wrong");

    a_table_last_addr: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_TBL_LAST)
        |=> s_q.prog_re && s_q.prog_addr == {LAST_PAGE, $past(table_pointer)})
        else $error("last page table address wrong");

    a_table_cur_addr: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_TBL_CUR)
        |=> s_q.prog_re && s_q.prog_addr == {$past(cur_page), $past(table_pointer)})
        else $error("current page table address wrong");

    a_xor_mem_write: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_XOR_MEM)
        |=> s_q.mem_we && s_q.mem_wdata == ($past(s_q.work) ^ $past(mem_rdata))
            && s_q.flags[FLAG_ZERO] == (s_q.mem_wdata == 8'h00) && $stable(s_q.work))
        else $error("xor to memory wrong");

    a_xor_imm_value: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op == MIES_OP_XOR_IMM)
        |=> s_q.work == ($past(s_q.work) ^ $past(instr.imm))
            && s_q.flags[FLAG_ZERO] == (s_q.work == 8'h00))
        else $error("xor immediate wrong");

    a_skip_flags_kept: assert property (@(posedge clock) disable iff (!rst_n_q)
        (issue_now && instr.op inside {MIES_OP_INC_WORK_SKIP, MIES_OP_SKIP_BIT_SET,
            MIES_OP_SKIP_BIT_CLR, MIES_OP_SKIP_ZERO, MIES_OP_TBL_CUR, MIES_OP_TBL_LAST})
        |=> $stable(s_q.flags))
        else $error("skip or table read altered flags");

    a_dummy_refuses: assert property (@(posedge clock) disable iff (!rst_n_q)
        (s_q.st == MIES_ST_DUMMY)
        |=> $stable(s_q.work) && $stable(s_q.flags) && !s_q.mem_we)
        else $error("request taken during dummy cycle");

endmodule : mies_exec
`default_nettype wire

// file: mies_mem_model.sv
// data memory and program memory model facing the exec subset
`timescale 1ns/1ps
`default_nettype none
module mies_mem_model
    import mies_pkg::*;
(
    input  wire logic               clock,
    input  wire logic [ADDR_W-1:0]  rd_addr,
    output logic      [DATA_W-1:0]  mem_rdata,
    input  wire logic               mem_we,
    input  wire logic [ADDR_W-1:0]  mem_addr,
    input  wire logic [DATA_W-1:0]  mem_wdata,
    input  wire logic               prog_re,
    input  wire logic [PADDR_W-1:0] prog_addr,
    output logic      [PROG_W-1:0]  prog_rdata
);
    logic [DATA_W-1:0] mem [256];
    logic [PROG_W-1:0] last_q;

    // word shows only while read enable is up; otherwise the previous output inverted, so an idle output toggles and stale data returns every other cycle
    assign prog_rdata = prog_re ? {prog_addr[11:4] ^ 8'h5A, prog_addr[7:0] ^ 8'hC3} : ~last_q;
    assign mem_rdata  = mem[rd_addr];

    always @(posedge clock) begin
        last_q <= prog_rdata;
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end
endmodule : mies_mem_model
`default_nettype wire

// file: test_mcu_instruction_exec_subset.sv
// self-checking bench for the instruction execution subset
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_exec_subset
    import mies_pkg::*;
;
    logic               clock = 1'b0;
    logic               nrst = 1'b0;
    logic               instr_valid = 1'b0;
    mies_instr_t        instr = '0;
    logic [PAGE_W-1:0]  table_pointer = 8'h00;
    logic [3:0]         cur_page = 4'h0;
    logic [DATA_W-1:0]  mem_rdata, mem_wdata, work_register, table_high_byte;
    logic [PROG_W-1:0]  prog_rdata;
    logic               busy, mem_we, prog_re, skip_next, done;
    logic [ADDR_W-1:0]  mem_addr;
    logic [PADDR_W-1:0] prog_addr;
    logic [3:0]         status_flags;
    logic [DATA_W-1:0]  shadow [256];
    logic [DATA_W-1:0]  w = WORK_RST;
    logic [DATA_W-1:0]  th = TBL_HI_RST;
    logic [3:0]         f = FLAGS_RST;
    int                 n_fail = 0;
    int                 check_count = 0;
    int                 cyc = 0;

    always #10 clock = ~clock;

    mies_exec u_mies_exec (.clock(clock), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
        .table_pointer(table_pointer), .cur_page(cur_page), .mem_rdata(mem_rdata),
        .prog_rdata(prog_rdata), .busy(busy), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .prog_re(prog_re), .prog_addr(prog_addr), .skip_next(skip_next),
        .done(done), .work_register(work_register), .table_high_byte(table_high_byte),
        .status_flags(status_flags));

    mies_mem_model u_mies_mem_model (.clock(clock), .rd_addr(instr.addr), .mem_rdata(mem_rdata),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .prog_re(prog_re),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // result byte, then flags {wrap, zero, nibble, carry}; carry and nibble mean no borrow
    function automatic logic [11:0] sub_ref(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        return {r, (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction : sub_ref

    task automatic exec(input mies_op_t op, input logic [7:0] a, input logic [7:0] imm,
                        input logic [2:0] bs);
        logic [7:0]  m;
        logic [7:0]  md;
        logic [11:0] pa;
        logic        sk;
        logic        seen_sk;
        int          n;
        int          en;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr       <= '{op, a, imm, bs};
        m = shadow[a];
        md = m;
        sk = 1'b0;
        seen_sk = 1'b0;
        n = 0;
        en = 0;
        case (op)
            MIES_OP_INC_WORK_SKIP: w = m + 8'h01;
            MIES_OP_SKIP_BIT_SET:  sk = m[bs];
            MIES_OP_SUB_WORK:      {w, f} = sub_ref(w, m);
            MIES_OP_SUB_MEM:       {md, f} = sub_ref(w, m);
            MIES_OP_SUB_IMM:       {w, f} = sub_ref(w, imm);
            MIES_OP_SWAP_MEM:      md = {m[3:0], m[7:4]};
            MIES_OP_SWAP_WORK:     w = {m[3:0], m[7:4]};
            MIES_OP_SKIP_ZERO:     sk = (m == 8'h00);
            MIES_OP_MOVE_SKIP:     w = m;
            MIES_OP_SKIP_BIT_CLR:  sk = !m[bs];
            MIES_OP_XOR_WORK:      w = w ^ m;
            MIES_OP_XOR_MEM:       md = w ^ m;
            MIES_OP_XOR_IMM:       w = w ^ imm;
            default: begin
                pa = {(op == MIES_OP_TBL_LAST) ? LAST_PAGE : cur_page, table_pointer};
                md = pa[7:0] ^ 8'hC3;
                th = pa[11:4] ^ 8'h5A;
                en = 1;
            end
        endcase
        if (op inside {MIES_OP_INC_WORK_SKIP, MIES_OP_MOVE_SKIP}) begin
            sk = (w == 8'h00);
        end
        if (op inside {MIES_OP_XOR_WORK, MIES_OP_XOR_IMM, MIES_OP_XOR_MEM}) begin
            f[FLAG_ZERO] = (op == MIES_OP_XOR_MEM) ? (md == 8'h00) : (w == 8'h00);
        end
        if (op inside {MIES_OP_INC_WORK_SKIP, MIES_OP_SKIP_BIT_SET, MIES_OP_SKIP_ZERO,
                       MIES_OP_MOVE_SKIP, MIES_OP_SKIP_BIT_CLR}) begin
            // an untaken skip completes like a plain instruction
            en = sk ? int'(SKIP_CYCLES) - 1 : 0;
        end
        shadow[a] = md;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        chk(busy, 16'(en > 0), "busy");
        if (op inside {MIES_OP_TBL_CUR, MIES_OP_TBL_LAST}) begin
            chk({prog_re, prog_addr}, {1'b1, pa}, "table address");
        end
        while (done !== 1'b1 && n < 4) begin
            seen_sk |= (skip_next === 1'b1);
            @(posedge clock);
            #1;
            n++;
        end
        seen_sk |= (skip_next === 1'b1);
        chk(done, 1'b1, "done");
        chk(seen_sk, sk, "skip");
        chk(16'(n), 16'(en), "cycles");
        chk(work_register, w, "work");
        chk(status_flags, f, "flags");
        chk(table_high_byte, th, "table high");
        // memory write lands at the edge that closes the done cycle
        @(posedge clock);
        #1;
        chk(u_mies_mem_model.mem[a], shadow[a], "memory");
    endtask : exec

    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 29);
        shadow[8'h01] = 8'hFF;
        shadow[8'h10] = 8'h80;
        for (int i = 0; i < 256; i++) u_mies_mem_model.mem[i] = shadow[i];
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        exec(MIES_OP_SUB_IMM, 8'h00, 8'h01, 3'h0);
        exec(MIES_OP_XOR_IMM, 8'h00, 8'hFF, 3'h0);
        exec(MIES_OP_INC_WORK_SKIP, 8'h01, 8'h00, 3'h0);
        exec(MIES_OP_INC_WORK_SKIP, 8'h02, 8'h00, 3'h0);
        exec(MIES_OP_SUB_WORK, 8'h03, 8'h00, 3'h0);
        exec(MIES_OP_SUB_MEM, 8'h04, 8'h00, 3'h0);
        for (int b = 0; b < 8; b++) begin
            exec(MIES_OP_SKIP_BIT_SET, 8'h05, 8'h00, 3'(b));
            exec(MIES_OP_SKIP_BIT_CLR, 8'h05, 8'h00, 3'(b));
        end
        exec(MIES_OP_SKIP_ZERO, 8'h00, 8'h00, 3'h0);
        exec(MIES_OP_SKIP_ZERO, 8'h06, 8'h00, 3'h0);
        exec(MIES_OP_MOVE_SKIP, 8'h00, 8'h00, 3'h0);
        exec(MIES_OP_MOVE_SKIP, 8'h07, 8'h00, 3'h0);
        exec(MIES_OP_SWAP_MEM, 8'h08, 8'h00, 3'h0);
        exec(MIES_OP_SWAP_WORK, 8'h09, 8'h00, 3'h0);
        @(posedge clock);
        cur_page      <= 4'h3;
        table_pointer <= 8'h45;
        exec(MIES_OP_TBL_CUR, 8'h0A, 8'h00, 3'h0);
        @(posedge clock);
        table_pointer <= 8'hFF;
        exec(MIES_OP_TBL_LAST, 8'h0B, 8'h00, 3'h0);
        exec(MIES_OP_XOR_WORK, 8'h0C, 8'h00, 3'h0);
        exec(MIES_OP_XOR_MEM, 8'h0D, 8'h00, 3'h0);
        exec(MIES_OP_MOVE_SKIP, 8'h10, 8'h00, 3'h0);
        exec(MIES_OP_SUB_IMM, 8'h00, 8'h01, 3'h0);
        exec(MIES_OP_SUB_IMM, 8'h00, 8'h7F, 3'h0);
        // a request held up while the skip's dummy cycle runs must be dropped
        @(posedge clock);
        instr_valid <= 1'b1;
        instr       <= '{MIES_OP_SKIP_ZERO, 8'h00, 8'h00, 3'h0};
        @(posedge clock);
        instr       <= '{MIES_OP_XOR_IMM, 8'h00, 8'hFF, 3'h0};
        @(posedge clock);
        instr_valid <= 1'b0;
        repeat (3) @(posedge clock);
        chk(work_register, w, "refused");
        print_verdict();
    end
endmodule : test_mcu_instruction_exec_subset
`default_nettype wire
